// *** inc/ext_clock_pkg.sv ***
// constants, register map and types of the external sample clock block
//
// Notes on behaviour
// - range register takes 64 for slow, 128 for fast; readable and writable.
// - 8 bit: high at 50.0, 25.0, 12.5 MHz for 1-2, 4, 8 channels.
// - 12-16 bit: high at 50.0, 25.0, 12.5, 6.0 MHz for 1, 2, 4, 8.
// - low range tolerates gaps; the first sample after a gap is suspect.
// - direct mode uses each rising edge of the incoming clock as a sample, unregenerated.
// - mode code 16 selects the divided external clock.
// - divider takes even ratios up to 8190; readable and writable.
// - in divided mode the range follows the divider output rate.
// - mode code 8 selects the direct external clock.
package ext_clock_pkg;

	localparam int ADDR_W = 20;

	// printed offsets are register indices; byte address is four times
	localparam logic [15:0] IDX_DIVIDE_RATIO  = 16'h4e48;
	localparam logic [15:0] IDX_RANGE_SELECT  = 16'h4ea2;
	localparam logic [15:0] IDX_SOURCE_SELECT = 16'h4ee8;
	localparam logic [19:0] ADDR_DIVIDE_RATIO  = {2'b00, IDX_DIVIDE_RATIO, 2'b00};
	localparam logic [19:0] ADDR_RANGE_SELECT  = {2'b00, IDX_RANGE_SELECT, 2'b00};
	localparam logic [19:0] ADDR_SOURCE_SELECT =
		{2'b00, IDX_SOURCE_SELECT, 2'b00};
	localparam logic [19:0] ADDR_CONTROL       = 20'h0_0000;
	localparam logic [19:0] ADDR_CHANNEL_MASK  = 20'h0_0004;
	localparam logic [19:0] ADDR_STATUS        = 20'h0_0008;
	localparam logic [19:0] ADDR_MEASURED_RATE = 20'h0_000c;

	// codes
	localparam logic [31:0] DIRECT_EXTERNAL_MODE  = 32'h0000_0008;
	localparam logic [31:0] DIVIDED_EXTERNAL_MODE = 32'h0000_0010;
	localparam logic [31:0] RANGE_LOW             = 32'h0000_0040;
	localparam logic [31:0] RANGE_HIGH            = 32'h0000_0080;

	// reset values
	localparam logic [31:0] RESET_SOURCE_SELECT = DIRECT_EXTERNAL_MODE;
	localparam logic [31:0] RESET_RANGE_SELECT  = RANGE_LOW;
	localparam logic [31:0] RESET_DIVIDE_RATIO  = 32'h0000_0002;

	// divider limits
	localparam int          DIV_W     = 13;
	localparam logic [12:0] DIV_MIN   = 13'h0002;
	localparam logic [12:0] DIV_MAX   = 13'h1ffe;

	// control and status fields
	localparam int CTRL_START_BIT      = 0;
	localparam int CTRL_STOP_BIT       = 1;
	localparam int FLAG_UNDER_RATE     = 0;
	localparam int FLAG_OVER_RATE      = 1;
	localparam int FLAG_RANGE_DRIFT    = 2;
	localparam int FLAG_HIGH_GAP       = 3;
	localparam int FLAG_START_REFUSED  = 4;
	localparam int FLAG_W              = 5;
	localparam int STAT_CLOCK_PRESENT  = 8;
	localparam int STAT_SUGGEST_HIGH   = 9;
	localparam int STAT_RUNNING        = 10;

	// rates in kHz, drift limits in percent
	localparam logic [31:0] MIN_RATE_KHZ = 32'h0000_03e8;
	localparam logic [31:0] MAX_RATE_KHZ = 32'h0001_86a0;
	localparam logic [31:0] THR_50M0_KHZ = 32'h0000_c350;
	localparam logic [31:0] THR_25M0_KHZ = 32'h0000_61a8;
	localparam logic [31:0] THR_12M5_KHZ = 32'h0000_30d4;
	localparam logic [31:0] THR_6M0_KHZ  = 32'h0000_1770;
	localparam logic [31:0] DRIFT_LOW_PCT  = 32'h0000_005f;
	localparam logic [31:0] DRIFT_HIGH_PCT = 32'h0000_0069;

	// timing
	localparam int CLK_PERIOD_NS = 8;
	localparam int GATE_NS       = 1000000;
	localparam int GATE_CYCLES   = GATE_NS / CLK_PERIOD_NS;
	localparam int GAP_NS        = 2000;
	localparam int GAP_CYCLES    = (GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	typedef enum logic [1:0] {
		ACQ_IDLE = 2'b00,
		ACQ_RUN  = 2'b01
	} acq_e;

endpackage

// *** rtl/ext_sample_clock.sv ***
// external sample clock selection, divider, rate monitor and ahb registers
//
// The AHB-Lite slave port is this design's own decision.
`timescale 1ns/1ps
module ext_sample_clock #(
	parameter int CONVERTER_BITS = 8,
	parameter int MODULES        = 2,
	parameter int CH_PER_MODULE  = 8,
	parameter int GATE_CYCLES    = ext_clock_pkg::GATE_CYCLES,
	parameter logic [31:0] MAX_RATE_KHZ = ext_clock_pkg::MAX_RATE_KHZ
) (
	// clock and reset
	input  wire logic        hclk,
	input  wire logic        hresetn,
	// ahb-lite slave
	input  wire logic        hsel,
	input  wire logic [19:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic        hready,
	input  wire logic [31:0] hwdata,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	// external clock input, sampled on hclk
	input  wire logic        ext_clk_in,
	// towards converters
	output logic             sample_enable,
	output logic             sample_suspect,
	output logic             acq_running,
	output logic             range_high
);

	localparam int CH_W   = MODULES * CH_PER_MODULE;
	localparam int GATE_W = $clog2(GATE_CYCLES + 1);
	localparam int GAP_W  = $clog2(ext_clock_pkg::GAP_CYCLES + 1);
	localparam int POP_W  = $clog2(CH_PER_MODULE + 1);
	localparam logic [63:0] GATE_REF = 64'(ext_clock_pkg::GATE_CYCLES);
	localparam logic [GATE_W-1:0] GATE_LAST = GATE_W'(GATE_CYCLES - 1);
	localparam logic [GAP_W-1:0]  GAP_LIMIT = GAP_W'(ext_clock_pkg::GAP_CYCLES);

	typedef struct packed {
		logic                      ext_prev;
		logic [31:0]               divide_ratio;
		logic [31:0]               range_sel;
		logic [31:0]               source_sel;
		logic [CH_W-1:0]           ch_mask;
		ext_clock_pkg::acq_e       acq;
		logic [12:0]               div_cnt;
		logic                      sample_en;
		logic                      suspect_pend;
		logic                      sample_suspect;
		logic [GATE_W-1:0]         gate_cnt;
		logic [31:0]               pulse_cnt;
		logic [31:0]               rate;
		logic                      rate_valid;
		logic [GAP_W-1:0]          idle_cnt;
		logic [ext_clock_pkg::FLAG_W-1:0] flags;
		logic                      wr_pend;
		logic [19:0]               wr_addr;
		logic [31:0]               rdata;
	} state_s;

	state_s r;
	state_s next_r;

	// active channels per module, worst module decides the range
	logic [POP_W-1:0] module_pop [MODULES];

	genvar m;
	generate
		for (m = 0; m < MODULES; m++) begin : g_pop
			always_comb begin
				module_pop[m] = '0;
				for (int c = 0; c < CH_PER_MODULE; c++) begin
					module_pop[m] = module_pop[m] +
						POP_W'(r.ch_mask[m*CH_PER_MODULE + c]);
				end
			end
		end
	endgenerate

	// high range threshold in kHz for the given active count
	function automatic logic [31:0] threshold_khz(input int active);
		logic [31:0] t;
		t = ext_clock_pkg::THR_50M0_KHZ;
		if (CONVERTER_BITS <= 8) begin
			if (active >= 5)
				t = ext_clock_pkg::THR_12M5_KHZ;
			else if (active >= 3)
				t = ext_clock_pkg::THR_25M0_KHZ;
		end else begin
			if (active >= 5)
				t = ext_clock_pkg::THR_6M0_KHZ;
			else if (active >= 3)
				t = ext_clock_pkg::THR_12M5_KHZ;
			else if (active == 2)
				t = ext_clock_pkg::THR_25M0_KHZ;
		end
		return t;
	endfunction

	int          active_max;
	logic [31:0] thr;
	logic [12:0] eff_ratio;
	logic        ext_rise;
	logic        fire;
	logic        gate_end;
	logic        sel_high;
	logic        suggest_high;
	logic        clock_present;
	logic        addr_ok;
	logic [ext_clock_pkg::FLAG_W-1:0] flag_set;
	logic [ext_clock_pkg::FLAG_W-1:0] flag_clr;
	logic [63:0] rate_scaled;
	logic [63:0] thr_scaled;

	always_comb begin
		active_max = 0;
		for (int i = 0; i < MODULES; i++) begin
			if (int'(module_pop[i]) > active_max)
				active_max = int'(module_pop[i]);
		end
		thr = threshold_khz(active_max);
	end

	// odd ratios round down, zero and one go to the smallest even ratio
	always_comb begin
		if (r.divide_ratio < 32'(ext_clock_pkg::DIV_MIN))
			eff_ratio = ext_clock_pkg::DIV_MIN;
		else if (r.divide_ratio > 32'(ext_clock_pkg::DIV_MAX))
			eff_ratio = ext_clock_pkg::DIV_MAX;
		else
			eff_ratio = {r.divide_ratio[12:1], 1'b0};
	end

	always_comb begin
		next_r = r;
		flag_set = '0;
		flag_clr = '0;
		fire = 1'b0;
		sel_high = (r.range_sel == ext_clock_pkg::RANGE_HIGH);
		clock_present = (r.idle_cnt < GAP_LIMIT);

		// external clock is only seen through hclk sampling
		ext_rise = ext_clk_in & ~r.ext_prev;
		next_r.ext_prev = ext_clk_in;

		if (ext_rise) begin
			if (r.source_sel == ext_clock_pkg::DIVIDED_EXTERNAL_MODE) begin
				if (r.div_cnt >= eff_ratio - 13'h0001) begin
					next_r.div_cnt = '0;
					fire = 1'b1;
				end else begin
					next_r.div_cnt = r.div_cnt + 13'h0001;
				end
			end else begin
				next_r.div_cnt = '0;
				fire = 1'b1;
			end
		end
		next_r.sample_en = fire;
		next_r.sample_suspect = fire & r.suspect_pend;
		if (fire)
			next_r.suspect_pend = 1'b0;

		// gap watch on raw input edges
		if (ext_rise) begin
			next_r.idle_cnt = '0;
		end else if (r.idle_cnt < GAP_LIMIT) begin
			next_r.idle_cnt = r.idle_cnt + GAP_W'(1);
			if (r.idle_cnt == GAP_LIMIT - GAP_W'(1)) begin
				if (sel_high && r.acq == ext_clock_pkg::ACQ_RUN)
					flag_set[ext_clock_pkg::FLAG_HIGH_GAP] = 1'b1;
				else
					next_r.suspect_pend = 1'b1;
			end
		end

		// rate of the sample pulses, so divided mode measures its output
		gate_end = (r.gate_cnt == GATE_LAST);
		if (gate_end) begin
			next_r.gate_cnt = '0;
			next_r.rate = r.pulse_cnt;
			next_r.rate_valid = 1'b1;
			next_r.pulse_cnt = {31'h0000_0000, fire};
		end else begin
			next_r.gate_cnt = r.gate_cnt + GATE_W'(1);
			if (fire && r.pulse_cnt != 32'hffff_ffff)
				next_r.pulse_cnt = r.pulse_cnt + 32'h0000_0001;
		end

		// compare per-gate counts with kHz limits, gate length scaled out
		rate_scaled = 64'(r.rate) * GATE_REF;
		thr_scaled = 64'(thr) * 64'(GATE_CYCLES);
		suggest_high = r.rate_valid && (rate_scaled >= thr_scaled);

		if (gate_end && r.rate_valid && r.acq == ext_clock_pkg::ACQ_RUN) begin
			if (rate_scaled <
				64'(ext_clock_pkg::MIN_RATE_KHZ) * 64'(GATE_CYCLES))
				flag_set[ext_clock_pkg::FLAG_UNDER_RATE] = 1'b1;
			if (rate_scaled > 64'(MAX_RATE_KHZ) * 64'(GATE_CYCLES))
				flag_set[ext_clock_pkg::FLAG_OVER_RATE] = 1'b1;
			if (sel_high && rate_scaled * 64'd100 <
				thr_scaled * 64'(ext_clock_pkg::DRIFT_LOW_PCT))
				flag_set[ext_clock_pkg::FLAG_RANGE_DRIFT] = 1'b1;
			if (!sel_high && rate_scaled * 64'd100 >
				thr_scaled * 64'(ext_clock_pkg::DRIFT_HIGH_PCT))
				flag_set[ext_clock_pkg::FLAG_RANGE_DRIFT] = 1'b1;
		end

		// ahb address phase: reads answer from flops in the data phase
		addr_ok = hsel & hready & htrans[1];
		next_r.wr_pend = addr_ok & hwrite;
		next_r.wr_addr = haddr;
		next_r.rdata = 32'h0000_0000;
		if (addr_ok && !hwrite) begin
			if (haddr == ext_clock_pkg::ADDR_DIVIDE_RATIO)
				next_r.rdata = r.divide_ratio;
			else if (haddr == ext_clock_pkg::ADDR_RANGE_SELECT)
				next_r.rdata = r.range_sel;
			else if (haddr == ext_clock_pkg::ADDR_SOURCE_SELECT)
				next_r.rdata = r.source_sel;
			else if (haddr == ext_clock_pkg::ADDR_CHANNEL_MASK)
				next_r.rdata = 32'(r.ch_mask);
			else if (haddr == ext_clock_pkg::ADDR_STATUS) begin
				next_r.rdata[ext_clock_pkg::FLAG_W-1:0] = r.flags;
				next_r.rdata[ext_clock_pkg::STAT_CLOCK_PRESENT] = clock_present;
				next_r.rdata[ext_clock_pkg::STAT_SUGGEST_HIGH] = suggest_high;
				next_r.rdata[ext_clock_pkg::STAT_RUNNING] =
					(r.acq == ext_clock_pkg::ACQ_RUN);
			end else if (haddr == ext_clock_pkg::ADDR_MEASURED_RATE)
				next_r.rdata = r.rate;
		end

		// ahb data phase writes
		if (r.wr_pend) begin
			if (r.wr_addr == ext_clock_pkg::ADDR_DIVIDE_RATIO) begin
				next_r.divide_ratio = hwdata;
				next_r.div_cnt = '0;
			end else if (r.wr_addr == ext_clock_pkg::ADDR_RANGE_SELECT) begin
				// other codes are ignored so the range stays defined
				if (hwdata == ext_clock_pkg::RANGE_LOW ||
					hwdata == ext_clock_pkg::RANGE_HIGH)
					next_r.range_sel = hwdata;
			end else if (r.wr_addr == ext_clock_pkg::ADDR_SOURCE_SELECT) begin
				if (hwdata == ext_clock_pkg::DIRECT_EXTERNAL_MODE ||
					hwdata == ext_clock_pkg::DIVIDED_EXTERNAL_MODE) begin
					next_r.source_sel = hwdata;
					next_r.div_cnt = '0;
				end
			end else if (r.wr_addr == ext_clock_pkg::ADDR_CHANNEL_MASK) begin
				next_r.ch_mask = hwdata[CH_W-1:0];
			end else if (r.wr_addr == ext_clock_pkg::ADDR_STATUS) begin
				flag_clr = hwdata[ext_clock_pkg::FLAG_W-1:0];
			end else if (r.wr_addr == ext_clock_pkg::ADDR_CONTROL) begin
				if (hwdata[ext_clock_pkg::CTRL_STOP_BIT]) begin
					next_r.acq = ext_clock_pkg::ACQ_IDLE;
				end else if (hwdata[ext_clock_pkg::CTRL_START_BIT]) begin
					case (r.acq)
						ext_clock_pkg::ACQ_IDLE: begin
							if (sel_high && !clock_present)
								flag_set[ext_clock_pkg::FLAG_START_REFUSED] =
									1'b1;
							else
								next_r.acq = ext_clock_pkg::ACQ_RUN;
						end
						default: next_r.acq = r.acq;
					endcase
				end
			end
		end

		// a flag raised in the clearing cycle survives
		next_r.flags = (r.flags & ~flag_clr) | flag_set;
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			r <= '0;
			r.divide_ratio <= ext_clock_pkg::RESET_DIVIDE_RATIO;
			r.range_sel <= ext_clock_pkg::RESET_RANGE_SELECT;
			r.source_sel <= ext_clock_pkg::RESET_SOURCE_SELECT;
			r.acq <= ext_clock_pkg::ACQ_IDLE;
			r.idle_cnt <= GAP_LIMIT;
		end else begin
			r <= next_r;
		end
	end

	assign hrdata = r.rdata;
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign sample_enable = r.sample_en;
	assign sample_suspect = r.sample_suspect;
	assign acq_running = (r.acq == ext_clock_pkg::ACQ_RUN);
	assign range_high = (r.range_sel == ext_clock_pkg::RANGE_HIGH);

endmodule

// *** verification/ext_clock_source.sv ***
// behavioural external sample clock source, stepped by the bench clock
`timescale 1ns/1ps
module ext_clock_source (
	// bench clock and control
	input  wire logic        hclk,
	input  wire logic        enable,
	input  wire logic [15:0] half,
	// clock towards the block
	output logic             ext_clk
);
	int cnt = 0;
	initial ext_clk = 1'b0;
	// stands still low between bursts, so gaps are only the bench's
	always @(posedge hclk) begin
		if (!enable) begin
			cnt <= 0;
			ext_clk <= 1'b0;
		end else begin
			// period 2*half cycles: about 0.95 kS/s to 62.5 MS/s, steady
			cnt <= (cnt == 2 * half - 1) ? 0 : cnt + 1;
			ext_clk <= (cnt < half);
		end
	end
endmodule

// *** verification/ext_sample_clock_assertions.sv ***
// concurrent checks on the ports of the external sample clock block
`timescale 1ns/1ps
module ext_sample_clock_checker (
	// clock and reset
	input wire logic        hclk,
	input wire logic        hresetn,
	// ahb-lite slave
	input wire logic        hsel,
	input wire logic [19:0] haddr,
	input wire logic [1:0]  htrans,
	input wire logic        hwrite,
	input wire logic [2:0]  hsize,
	input wire logic        hready,
	input wire logic [31:0] hwdata,
	input wire logic [31:0] hrdata,
	input wire logic        hreadyout,
	input wire logic        hresp,
	// sample side
	input wire logic        ext_clk_in,
	input wire logic        sample_enable,
	input wire logic        sample_suspect,
	input wire logic        acq_running,
	input wire logic        range_high
);
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	logic        wr_q;
	logic        rd_q;
	logic [19:0] addr_q;
	logic        direct_q;
	// shadow of the mode; illegal codes are ignored like the block does
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_q     <= 1'b0;
			rd_q     <= 1'b0;
			addr_q   <= 20'h0_0000;
			direct_q <= 1'b1;
		end else begin
			wr_q   <= hsel && hready && htrans[1] && hwrite;
			rd_q   <= hsel && hready && htrans[1] && !hwrite;
			addr_q <= haddr;
			if (wr_q && addr_q == ext_clock_pkg::ADDR_SOURCE_SELECT &&
			    hwdata inside {32'h0000_0008, 32'h0000_0010})
				direct_q <= (hwdata == 32'h0000_0008);
		end
	end
	sequence s_range_wr(logic [31:0] code);
		wr_q && addr_q == ext_clock_pkg::ADDR_RANGE_SELECT && hwdata == code;
	endsequence
	sequence s_ext_rise;
		$rose(ext_clk_in);
	endsequence
	property p_okay;
		hresp == 1'b0 && hreadyout == 1'b1;
	endproperty
	a_okay: assert property (p_okay) else $error("bus answer not okay");
	property p_range_high;
		s_range_wr(32'h0000_0080) |=> range_high;
	endproperty
	a_range_high: assert property (p_range_high)
		else $error("range code 128 not taken");
	property p_range_low;
		s_range_wr(32'h0000_0040) |=> !range_high;
	endproperty
	a_range_low: assert property (p_range_low)
		else $error("range code 64 not taken");
	property p_range_keep;
		wr_q && addr_q == ext_clock_pkg::ADDR_RANGE_SELECT &&
		!(hwdata inside {32'h0000_0040, 32'h0000_0080}) |=> $stable(range_high);
	endproperty
	a_range_keep: assert property (p_range_keep)
		else $error("illegal range code changed range");
	property p_range_read;
		rd_q && addr_q == ext_clock_pkg::ADDR_RANGE_SELECT |->
		hrdata inside {32'h0000_0040, 32'h0000_0080};
	endproperty
	a_range_read: assert property (p_range_read)
		else $error("range reads an illegal code");
	property p_mode_read;
		rd_q && addr_q == ext_clock_pkg::ADDR_SOURCE_SELECT |->
		hrdata inside {32'h0000_0008, 32'h0000_0010};
	endproperty
	a_mode_read: assert property (p_mode_read)
		else $error("mode reads an illegal code");
	property p_direct;
		direct_q ##0 s_ext_rise |=> sample_enable;
	endproperty
	a_direct: assert property (p_direct)
		else $error("direct mode missed an edge");
	property p_cause;
		sample_enable |-> $past(ext_clk_in) && !$past(ext_clk_in, 2);
	endproperty
	a_cause: assert property (p_cause)
		else $error("sample without a rising edge");
	property p_single;
		sample_enable |=> !sample_enable;
	endproperty
	a_single: assert property (p_single)
		else $error("sample pulse longer than one cycle");
	property p_suspect;
		sample_suspect |-> sample_enable;
	endproperty
	a_suspect: assert property (p_suspect)
		else $error("suspect flag without a sample");
endmodule
bind ext_sample_clock ext_sample_clock_checker u_chk (.hclk(hclk),
	.hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
	.hwrite(hwrite), .hsize(hsize), .hready(hready), .hwdata(hwdata),
	.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
	.ext_clk_in(ext_clk_in), .sample_enable(sample_enable),
	.sample_suspect(sample_suspect), .acq_running(acq_running),
	.range_high(range_high));

// *** verification/tb_top.sv ***
// self-checking bench for the external sample clock block
`timescale 1ns/1ps
module tb_top;
	logic        hclk;
	logic        hresetn;
	logic        hsel;
	logic [19:0] haddr;
	logic [1:0]  htrans;
	logic        hwrite;
	logic [2:0]  hsize;
	logic [31:0] hwdata;
	logic [31:0] hrdata;
	logic        hreadyout;
	logic        hresp;
	logic        ext_clk_in;
	logic        sample_enable;
	logic        sample_suspect;
	logic        acq_running;
	logic        range_high;
	logic        ck_en;
	logic [15:0] ck_half;
	logic [31:0] q;
	int          fails;
	int          num_checks;
	int          n_se;
	int          n_su;
	int          raw[6]  = '{4, 5, 0, 1, 8190, 9000};
	int          per[6]  = '{12, 12, 12, 7, 8190, 8191};
	int          expn[6] = '{3, 3, 6, 3, 1, 1};

	ext_sample_clock #(.GATE_CYCLES(200)) DUT (.hclk(hclk), .hresetn(hresetn),
		.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(hsize), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .ext_clk_in(ext_clk_in),
		.sample_enable(sample_enable), .sample_suspect(sample_suspect),
		.acq_running(acq_running), .range_high(range_high));
	ext_clock_source u_src (.hclk(hclk), .enable(ck_en), .half(ck_half),
		.ext_clk(ext_clk_in));

	initial begin
		hclk = 1'b0;
		forever #4 hclk = ~hclk;
	end

	always @(posedge hclk) begin
		if (sample_enable === 1'b1) n_se++;
		if (sample_suspect === 1'b1) n_su++;
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			fails++;
			$display("[ERR] %0t ns: got %h, expected %h", $time, got, exp);
		end
	endtask

	task automatic bus(input logic w, input logic [19:0] a,
		input logic [31:0] d);
		hsel   <= 1'b1;
		haddr  <= a;
		hwrite <= w;
		htrans <= 2'b10;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		hsel   <= 1'b0;
		htrans <= 2'b00;
		hwdata <= w ? d : 32'h0000_0000;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		q = hrdata;
	endtask

	task automatic rd(input logic [19:0] a, input logic [31:0] exp);
		bus(1'b0, a, 32'h0000_0000);
		chk(q, exp);
	endtask

	// clock runs per periods, then a 300 cycle gap, longer than 250
	task automatic burst(input int half, input int per);
		n_se = 0;
		n_su = 0;
		ck_half <= half[15:0];
		ck_en <= 1'b1;
		repeat (2 * half * per) @(posedge hclk);
		ck_en <= 1'b0;
		repeat (300) @(posedge hclk);
	endtask

	task automatic print_verdict;
		$display("checks %0d, mismatches %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	initial begin
		repeat (60000) @(posedge hclk);
		fails++;
		print_verdict;
	end

	initial begin
		{hresetn, hsel, haddr, htrans, hwrite, hwdata} = '0;
		{ck_en, ck_half, fails, num_checks, n_se, n_su} = '0;
		hsize = 3'b010;
		repeat (6) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		rd(ext_clock_pkg::ADDR_DIVIDE_RATIO, 32'h0000_0002);
		rd(ext_clock_pkg::ADDR_RANGE_SELECT, 32'h0000_0040);
		rd(ext_clock_pkg::ADDR_SOURCE_SELECT, 32'h0000_0008);
		rd(20'h0_0400, 32'h0000_0000);
		$display("test reset values done");
		bus(1'b1, ext_clock_pkg::ADDR_RANGE_SELECT, 32'h0000_0080);
		rd(ext_clock_pkg::ADDR_RANGE_SELECT, 32'h0000_0080);
		chk({31'h0, range_high}, 32'h0000_0001);
		bus(1'b1, ext_clock_pkg::ADDR_RANGE_SELECT, 32'h0000_0063);
		rd(ext_clock_pkg::ADDR_RANGE_SELECT, 32'h0000_0080);
		// start in high range with no clock present must be refused
		bus(1'b1, ext_clock_pkg::ADDR_CONTROL, 32'h0000_0001);
		bus(1'b0, ext_clock_pkg::ADDR_STATUS, 32'h0000_0000);
		chk(q & 32'h0000_0510, 32'h0000_0010);
		chk({31'h0, acq_running}, 32'h0000_0000);
		bus(1'b1, ext_clock_pkg::ADDR_STATUS, 32'h0000_0010);
		bus(1'b0, ext_clock_pkg::ADDR_STATUS, 32'h0000_0000);
		chk(q & 32'h0000_0010, 32'h0000_0000);
		bus(1'b1, ext_clock_pkg::ADDR_RANGE_SELECT, 32'h0000_0040);
		// write lands on the edge the task returns at, look one later
		@(posedge hclk);
		chk({31'h0, range_high}, 32'h0000_0000);
		$display("test range codes done");
		burst(3, 10);
		chk(n_se, 10);
		// no gap has ended since reset, so nothing is suspect yet
		chk(n_su, 0);
		// low range runs on a gapped clock
		bus(1'b1, ext_clock_pkg::ADDR_CONTROL, 32'h0000_0001);
		burst(2, 5);
		chk({31'h0, acq_running}, 32'h0000_0001);
		chk(n_se, 5);
		chk(n_su, 1);
		bus(1'b1, ext_clock_pkg::ADDR_CONTROL, 32'h0000_0002);
		$display("test direct clock done");
		bus(1'b1, ext_clock_pkg::ADDR_SOURCE_SELECT, 32'h0000_0010);
		bus(1'b1, ext_clock_pkg::ADDR_SOURCE_SELECT, 32'h0000_0003);
		rd(ext_clock_pkg::ADDR_SOURCE_SELECT, 32'h0000_0010);
		for (int i = 0; i < 6; i++) begin
			bus(1'b1, ext_clock_pkg::ADDR_DIVIDE_RATIO, raw[i]);
			rd(ext_clock_pkg::ADDR_DIVIDE_RATIO, raw[i]);
			burst(1, per[i]);
			chk(n_se, expn[i]);
		end
		$display("test divided clock done");
		// ratio 2 on a 62.5 MHz input: 50 pulses per 200 cycle gate
		bus(1'b1, ext_clock_pkg::ADDR_DIVIDE_RATIO, 32'h0000_0002);
		ck_half <= 16'h0001;
		ck_en <= 1'b1;
		repeat (500) @(posedge hclk);
		rd(ext_clock_pkg::ADDR_MEASURED_RATE, 32'h0000_0032);
		// no channels: 50.0 MHz threshold, divided output stays low range
		bus(1'b0, ext_clock_pkg::ADDR_STATUS, 32'h0000_0000);
		chk(q & 32'h0000_0200, 32'h0000_0000);
		// four channels on one module: 25.0 MHz threshold, high range
		bus(1'b1, ext_clock_pkg::ADDR_CHANNEL_MASK, 32'h0000_000f);
		bus(1'b0, ext_clock_pkg::ADDR_STATUS, 32'h0000_0000);
		chk(q & 32'h0000_0200, 32'h0000_0200);
		ck_en <= 1'b0;
		$display("test divided rate done");
		bus(1'b1, ext_clock_pkg::ADDR_SOURCE_SELECT, 32'h0000_0008);
		rd(ext_clock_pkg::ADDR_SOURCE_SELECT, 32'h0000_0008);
		burst(1, 4);
		chk(n_se, 4);
		$display("test back to direct done");
		print_verdict;
	end
endmodule
